// File: logic/uflfc_pkg.sv
// Constants, types and helpers shared by the serial port files
package uflfc_pkg;
  // ***********************************
  // Widths and depths
  // ***********************************
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 3;
  localparam int IER_W = 4;
  localparam int MCR_W = 5;
  localparam int CNT_W = 20;
  // ***********************************
  // Register offsets
  // ***********************************
  localparam logic [9:0] IO_FIFO_CONTROL = 10'h3fa;
  localparam logic [9:0] IO_LINE_FORMAT = 10'h3fb;
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR_FCR = IO_FIFO_CONTROL[2:0];
  localparam logic [2:0] OFS_LCR = IO_LINE_FORMAT[2:0];
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  // ***********************************
  // Field positions
  // ***********************************
  localparam int LCR_WL_HI = 1;
  localparam int LCR_WL_LO = 0;
  localparam int LCR_STOP = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BREAK = 6;
  localparam int LCR_DIVISOR_ACCESS_SELECT = 7;
  localparam int FCR_EN = 0;
  localparam int FCR_RXCLR = 1;
  localparam int FCR_TXCLR = 2;
  localparam int FCR_TRIG_HI = 7;
  localparam int FCR_TRIG_LO = 6;
  localparam int IER_RDA = 0;
  localparam int IER_THRE = 1;
  localparam int IER_RLS = 2;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_LOOP = 4;
  // ***********************************
  // Codes, levels and reset values
  // ***********************************
  localparam logic [3:0] TRIG_LVL [4] = '{4'h1, 4'h4, 4'h8, 4'he};
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_RLS = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_THRE = 4'h2;
  localparam logic [1:0] IIR_FIFO_ON = 2'h3;
  localparam logic [1:0] WLEN_5 = 2'h0;
  localparam logic [1:0] WLEN_8 = 2'h3;
  localparam logic [2:0] WLEN_LAST_BASE = 3'h4;
  localparam logic [2:0] HALF_START = 3'h1;
  localparam logic [2:0] HALF_BIT = 3'h2;
  localparam logic [2:0] HALF_STOP_1P5 = 3'h3;
  localparam logic [2:0] HALF_STOP_2 = 3'h4;
  localparam logic [16:0] HALF_MIN = 17'h00001;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  // Shared state code for both serial engines
  typedef enum logic [4:0] {
    SER_IDLE = 5'h01,
    SER_START = 5'h02,
    SER_DATA = 5'h04,
    SER_PARITY = 5'h08,
    SER_STOP = 5'h10
  } uflfc_ser_state_t;
  // Parity of the used data bits, or the stuck level
  function automatic logic uflfc_parity(input logic [7:0] d, input logic [7:0] line_format_control);
    logic [7:0] m;
    m = d & (8'hff >> (WLEN_8 - line_format_control[LCR_WL_HI:LCR_WL_LO]));
    if (line_format_control[LCR_STICK])
      return ~line_format_control[LCR_EPS];
    return line_format_control[LCR_EPS] ? ^m : ~^m;
  endfunction
  // Half-bit count to a down-counter load value
  function automatic logic [CNT_W-1:0] uflfc_halves(input logic [2:0] n, input logic [16:0] h);
    logic [CNT_W-1:0] p;
    p = CNT_W'(n) * CNT_W'(h);
    return p - CNT_W'(1);
  endfunction
endpackage

// File: logic/uflfc_fifo_if.sv
// Carrier between a FIFO and its user
interface uflfc_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 8);
  localparam int CW = $clog2(DEPTH + 1);
  logic wr_valid; // Push request
  logic wr_ready; // Room for a word
  logic [WIDTH-1:0] wr_data;
  logic rd_valid; // Word available
  logic rd_ready; // Pop request
  logic [WIDTH-1:0] rd_data;
  logic clear; // Discard all words
  logic [CW-1:0] level; // Words held
  modport fifo (input wr_valid, wr_data, rd_ready, clear, output wr_ready, rd_valid, rd_data, level);
  modport user (output wr_valid, wr_data, rd_ready, clear, input wr_ready, rd_valid, rd_data, level);
endinterface

// File: logic/uflfc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module uflfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  uflfc_fifo_if.fifo q
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage
  logic [PW-1:0] wptr_reg; // Write index
  logic [PW-1:0] rptr_reg; // Read index
  logic [CW-1:0] count_reg; // Occupancy
  wire push = q.wr_valid & q.wr_ready;
  wire pop = q.rd_valid & q.rd_ready;
  assign q.wr_ready = count_reg != CW'(DEPTH);
  assign q.rd_valid = count_reg != '0;
  assign q.rd_data = mem_reg[rptr_reg];
  assign q.level = count_reg;
  // Wrap for depths that are not a power of two
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction
  // Pointers and count; clear beats a push
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end
    else if (q.clear)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= bump(wptr_reg);
      if (pop)
        rptr_reg <= bump(rptr_reg);
      count_reg <= CW'(count_reg + CW'(push) - CW'(pop));
    end
  end
  // Data storage needs no reset
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wptr_reg] <= q.wr_data;
  end
endmodule // uflfc_fifo

// File: logic/uflfc_top.sv
// Serial port register select, FIFO control and line format
module uflfc_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_port_select_n,
  input wire logic [uflfc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [uflfc_pkg::DATA_W-1:0] bus_wdata,
  output logic [uflfc_pkg::DATA_W-1:0] bus_rdata,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic dtr_n,
  output logic rts_n
);
  import uflfc_pkg::*;
  // ***********************************
  // State
  // ***********************************
  logic [7:0] lcr_reg; // Line format
  logic [7:0] scratch_reg; // Scratch
  logic [7:0] divisor_low_reg; // Divisor low
  logic [7:0] divisor_high_byte_reg; // Divisor high
  logic [7:0] bus_rdata_reg; // Read data
  logic [IER_W-1:0] ier_reg; // Interrupt enables
  logic [MCR_W-1:0] mcr_reg; // Modem control
  logic fifo_en_reg; // FIFO mode
  logic [1:0] trig_reg; // Trigger select
  logic [3:0] err_reg; // Sticky errors
  logic [3:0] err_next;
  logic thre_irq_reg; // Holding empty event
  logic thre_irq_next;
  logic tx_empty_d_reg; // Empty, delayed
  logic serial_out_reg;
  logic dtr_n_reg;
  logic rts_n_reg;
  uflfc_ser_state_t tx_state_reg, tx_state_next;
  uflfc_ser_state_t rx_state_reg, rx_state_next;
  logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
  logic [CNT_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [7:0] tx_char_reg, tx_char_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic rx_par_reg, rx_par_next;
  logic [7:0] rd_mux; // Read select
  // Eight-word queues in each direction
  uflfc_fifo_if #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) txq ();
  uflfc_fifo_if #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rxq ();
  uflfc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .sys_clk(sys_clk),
    .rst(rst),
    .q(txq)
  );
  uflfc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rxq (
    .sys_clk(sys_clk),
    .rst(rst),
    .q(rxq)
  );
  // ***********************************
  // Address decode
  // ***********************************
  wire divisor_access_select = lcr_reg[LCR_DIVISOR_ACCESS_SELECT];
  wire acc_wr = bus_wr & ~serial_port_select_n;
  wire acc_rd = bus_rd & ~serial_port_select_n;
  wire hit_data = bus_addr == OFS_DATA;
  wire hit_ier = bus_addr == OFS_IER;
  wire dl = divisor_access_select;
  wire wr_thr = acc_wr & hit_data & ~dl;
  wire wr_dll = acc_wr & hit_data & dl;
  wire wr_ier = acc_wr & hit_ier & ~dl;
  wire wr_dlm = acc_wr & hit_ier & dl;
  wire wr_fcr = acc_wr & (bus_addr == OFS_IIR_FCR);
  wire wr_lcr = acc_wr & (bus_addr == OFS_LCR);
  wire wr_mcr = acc_wr & (bus_addr == OFS_MCR);
  wire wr_scr = acc_wr & (bus_addr == OFS_SCRATCH);
  wire rd_rbr = acc_rd & hit_data & ~dl;
  wire rd_iir = acc_rd & (bus_addr == OFS_IIR_FCR);
  wire rd_lsr = acc_rd & (bus_addr == OFS_LSR);
  // ***********************************
  // Format and timing
  // ***********************************
  wire [1:0] wlen = lcr_reg[LCR_WL_HI:LCR_WL_LO];
  wire [2:0] last_bit = WLEN_LAST_BASE + {1'b0, wlen};
  wire pen = lcr_reg[LCR_PEN];
  wire [15:0] divisor = {divisor_high_byte_reg, divisor_low_reg};
  // A zero divisor runs at the fastest rate instead of stalling
  wire [16:0] half_cyc = (divisor == '0) ? HALF_MIN : {1'b0, divisor};
  wire [CNT_W-1:0] bit_load = uflfc_halves(HALF_BIT, half_cyc);
  wire [CNT_W-1:0] mid_load = uflfc_halves(HALF_START, half_cyc);
  wire [2:0] stop_halves = ~lcr_reg[LCR_STOP] ? HALF_BIT :
                           (wlen == WLEN_5) ? HALF_STOP_1P5 : HALF_STOP_2;
  wire [CNT_W-1:0] stop_load = uflfc_halves(stop_halves, half_cyc);
  wire [3:0] trig_level = TRIG_LVL[trig_reg];
  // ***********************************
  // FIFO hookup
  // ***********************************
  // Without FIFO mode each queue acts as a single holding byte
  wire tx_space = fifo_en_reg ? txq.wr_ready : ~txq.rd_valid;
  wire rx_space = fifo_en_reg ? rxq.wr_ready : ~rxq.rd_valid;
  assign txq.wr_valid = wr_thr & tx_space;
  assign txq.wr_data = bus_wdata;
  assign txq.rd_ready = tx_state_reg == SER_IDLE;
  // Flush on clear-of-enable, or bit 1/2 while enabling
  wire en_drop = fifo_en_reg & ~bus_wdata[FCR_EN];
  assign rxq.clear = wr_fcr & (en_drop | (bus_wdata[FCR_EN] & bus_wdata[FCR_RXCLR]));
  assign txq.clear = wr_fcr & (en_drop | (bus_wdata[FCR_EN] & bus_wdata[FCR_TXCLR]));
  assign rxq.rd_ready = rd_rbr;
  // ***********************************
  // Serial line
  // ***********************************
  wire tx_par = uflfc_parity(tx_char_reg, lcr_reg);
  wire tx_line = (tx_state_reg == SER_START) ? 1'b0 :
                 (tx_state_reg == SER_DATA) ? tx_char_reg[tx_bit_reg] :
                 (tx_state_reg == SER_PARITY) ? tx_par : 1'b1;
  wire rx_in = mcr_reg[MCR_LOOP] ? tx_line : serial_in;
  wire [7:0] rx_char = rx_shift_reg >> (WLEN_8 - wlen);
  wire rx_done = (rx_state_reg == SER_STOP) && (rx_cnt_reg == '0);
  wire pe = pen & (rx_par_reg != uflfc_parity(rx_char, lcr_reg));
  wire bi = (rx_char == '0) & ~rx_in & ~(pen & rx_par_reg);
  wire [3:0] err_set = rx_done ? {bi, ~rx_in, pe, ~rx_space} : 4'h0;
  assign rxq.wr_valid = rx_done & rx_space;
  assign rxq.wr_data = rx_char;
  // ***********************************
  // Status and identification
  // ***********************************
  wire tx_empty = ~txq.rd_valid;
  wire temt = tx_empty & (tx_state_reg == SER_IDLE);
  wire [7:0] lsr = {1'b0, temt, tx_empty, err_reg, rxq.rd_valid};
  wire rls_p = ier_reg[IER_RLS] & (|err_reg);
  wire rda_p = ier_reg[IER_RDA] & (fifo_en_reg ? (rxq.level >= trig_level) : rxq.rd_valid);
  wire thre_p = ier_reg[IER_THRE] & thre_irq_reg;
  wire [3:0] iir_code = rls_p ? IIR_RLS : rda_p ? IIR_RDA : thre_p ? IIR_THRE : IIR_NONE;
  wire [1:0] iir_top = fifo_en_reg ? IIR_FIFO_ON : 2'h0;
  wire [7:0] msr = {~dcd_n, ~ri_n, ~dsr_n, ~cts_n, 4'h0};
  // Set wins over a same-cycle clear
  assign err_next = err_set | (rd_lsr ? 4'h0 : err_reg);
  wire thre_clr = wr_thr | (rd_iir & (iir_code == IIR_THRE));
  assign thre_irq_next = (tx_empty & ~tx_empty_d_reg) | (thre_irq_reg & ~thre_clr);
  // Read select
  always_comb
  begin
    case (bus_addr)
      OFS_DATA: rd_mux = dl ? divisor_low_reg : rxq.rd_data;
      OFS_IER: rd_mux = dl ? divisor_high_byte_reg : {4'h0, ier_reg};
      OFS_IIR_FCR: rd_mux = {iir_top, 2'h0, iir_code};
      OFS_LCR: rd_mux = lcr_reg;
      OFS_MCR: rd_mux = {3'h0, mcr_reg};
      OFS_LSR: rd_mux = lsr;
      OFS_MSR: rd_mux = msr;
      default: rd_mux = scratch_reg;
    endcase
  end
  // ***********************************
  // Host registers
  // ***********************************
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lcr_reg <= BYTE_RESET;
      fifo_en_reg <= 1'b0;
      trig_reg <= TRIG_RESET;
      ier_reg <= '0;
      mcr_reg <= '0;
      scratch_reg <= BYTE_RESET;
      divisor_low_reg <= BYTE_RESET;
      divisor_high_byte_reg <= BYTE_RESET;
      bus_rdata_reg <= BYTE_RESET;
      err_reg <= 4'h0;
      thre_irq_reg <= 1'b0;
      tx_empty_d_reg <= 1'b1;
    end
    else
    begin
      if (wr_lcr)
        lcr_reg <= bus_wdata;
      if (wr_fcr)
      begin
        fifo_en_reg <= bus_wdata[FCR_EN];
        trig_reg <= bus_wdata[FCR_TRIG_HI:FCR_TRIG_LO];
      end
      if (wr_ier)
        ier_reg <= bus_wdata[IER_W-1:0];
      if (wr_mcr)
        mcr_reg <= bus_wdata[MCR_W-1:0];
      if (wr_scr)
        scratch_reg <= bus_wdata;
      if (wr_dll)
        divisor_low_reg <= bus_wdata;
      if (wr_dlm)
        divisor_high_byte_reg <= bus_wdata;
      if (acc_rd)
        bus_rdata_reg <= rd_mux;
      err_reg <= err_next;
      thre_irq_reg <= thre_irq_next;
      tx_empty_d_reg <= tx_empty;
    end
  end
  // ***********************************
  // Transmit engine
  // ***********************************
  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_char_next = tx_char_reg;
    tx_bit_next = tx_bit_reg;
    tx_cnt_next = (tx_cnt_reg == '0) ? tx_cnt_reg : tx_cnt_reg - CNT_W'(1);
    case (tx_state_reg)
      SER_IDLE:
        if (txq.rd_valid)
        begin
          tx_char_next = txq.rd_data;
          tx_cnt_next = bit_load;
          tx_state_next = SER_START;
        end
      SER_START:
        if (tx_cnt_reg == '0)
        begin
          tx_bit_next = 3'h0;
          tx_cnt_next = bit_load;
          tx_state_next = SER_DATA;
        end
      SER_DATA:
        if (tx_cnt_reg == '0)
        begin
          // Parity sits between last data bit and stop
          tx_bit_next = 3'(tx_bit_reg + 3'h1);
          tx_cnt_next = pen ? bit_load : stop_load;
          if (tx_bit_reg != last_bit)
            tx_cnt_next = bit_load;
          else
            tx_state_next = pen ? SER_PARITY : SER_STOP;
        end
      SER_PARITY:
        if (tx_cnt_reg == '0)
        begin
          tx_cnt_next = stop_load;
          tx_state_next = SER_STOP;
        end
      SER_STOP:
        if (tx_cnt_reg == '0)
          tx_state_next = SER_IDLE;
      default:
        tx_state_next = SER_IDLE;
    endcase
  end
  // ***********************************
  // Receive engine
  // ***********************************
  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_bit_next = rx_bit_reg;
    rx_par_next = rx_par_reg;
    rx_cnt_next = (rx_cnt_reg == '0) ? rx_cnt_reg : rx_cnt_reg - CNT_W'(1);
    case (rx_state_reg)
      SER_IDLE:
        if (~rx_in)
        begin
          rx_cnt_next = mid_load;
          rx_state_next = SER_START;
        end
      SER_START:
        if (rx_cnt_reg == '0)
        begin
          // A glitch shorter than half a bit is dropped
          rx_bit_next = 3'h0;
          rx_cnt_next = bit_load;
          rx_state_next = rx_in ? SER_IDLE : SER_DATA;
        end
      SER_DATA:
        if (rx_cnt_reg == '0)
        begin
          rx_shift_next = {rx_in, rx_shift_reg[7:1]};
          rx_bit_next = 3'(rx_bit_reg + 3'h1);
          rx_cnt_next = bit_load;
          if (rx_bit_reg == last_bit)
            rx_state_next = pen ? SER_PARITY : SER_STOP;
        end
      SER_PARITY:
        if (rx_cnt_reg == '0)
        begin
          rx_par_next = rx_in;
          rx_cnt_next = bit_load;
          rx_state_next = SER_STOP;
        end
      SER_STOP:
        // Later stop bits are never looked at
        if (rx_cnt_reg == '0)
          rx_state_next = SER_IDLE;
      default:
        rx_state_next = SER_IDLE;
    endcase
  end
  // Engine flops and pins
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_reg <= SER_IDLE;
      tx_char_reg <= BYTE_RESET;
      tx_bit_reg <= 3'h0;
      tx_cnt_reg <= '0;
      rx_state_reg <= SER_IDLE;
      rx_shift_reg <= BYTE_RESET;
      rx_bit_reg <= 3'h0;
      rx_cnt_reg <= '0;
      rx_par_reg <= 1'b0;
      serial_out_reg <= 1'b1;
      dtr_n_reg <= 1'b1;
      rts_n_reg <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_char_reg <= tx_char_next;
      tx_bit_reg <= tx_bit_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_bit_reg <= rx_bit_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_par_reg <= rx_par_next;
      // Break only masks the pin; loopback marks it
      serial_out_reg <= mcr_reg[MCR_LOOP] | (tx_line & ~lcr_reg[LCR_BREAK]);
      dtr_n_reg <= mcr_reg[MCR_LOOP] | ~mcr_reg[MCR_DTR];
      rts_n_reg <= mcr_reg[MCR_LOOP] | ~mcr_reg[MCR_RTS];
    end
  end
  assign bus_rdata = bus_rdata_reg;
  assign serial_out = serial_out_reg;
  assign dtr_n = dtr_n_reg;
  assign rts_n = rts_n_reg;
  // ***********************************
  // Checks
  // ***********************************
  property p_flush_all;
    @(posedge sys_clk) disable iff (rst)
    wr_fcr && fifo_en_reg && !bus_wdata[FCR_EN] |=> rxq.level == '0 && txq.level == '0;
  endproperty
  a_flush_all: assert property (p_flush_all) else $error("FIFO disable did not flush");
  property p_rx_flush;
    @(posedge sys_clk) disable iff (rst)
    wr_fcr && bus_wdata[FCR_EN] && bus_wdata[FCR_RXCLR] |=> rxq.level == '0 && !rxq.rd_valid;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("receive flush failed");
  property p_tx_flush;
    @(posedge sys_clk) disable iff (rst)
    wr_fcr && bus_wdata[FCR_EN] && bus_wdata[FCR_TXCLR] |=> txq.level == '0 && !txq.rd_valid;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("transmit flush failed");
  property p_rbr_read;
    @(posedge sys_clk) disable iff (rst)
    rd_rbr && rxq.rd_valid |=> bus_rdata == $past(rxq.rd_data);
  endproperty
  a_rbr_read: assert property (p_rbr_read) else $error("receive read wrong");
  property p_dlm_write;
    @(posedge sys_clk) disable iff (rst)
    acc_wr && dl && hit_ier |=> divisor_high_byte_reg == $past(bus_wdata) && ier_reg == $past(ier_reg);
  endproperty
  a_dlm_write: assert property (p_dlm_write) else $error("divisor high write wrong");
  property p_ignore;
    @(posedge sys_clk) disable iff (rst)
    serial_port_select_n && (bus_wr || bus_rd) |=> $stable(lcr_reg) && $stable(scratch_reg) && $stable(bus_rdata);
  endproperty
  a_ignore: assert property (p_ignore) else $error("access without select");
  property p_lcr_back;
    @(posedge sys_clk) disable iff (rst)
    wr_lcr ##1 (acc_rd && bus_addr == OFS_LCR && !wr_lcr) |=> bus_rdata == $past(bus_wdata, 2);
  endproperty
  a_lcr_back: assert property (p_lcr_back) else $error("line control readback wrong");
  property p_stop_1p5;
    @(posedge sys_clk) disable iff (rst)
    tx_state_reg != SER_STOP && tx_state_next == SER_STOP && lcr_reg[LCR_STOP] && wlen == WLEN_5
    |=> tx_cnt_reg == CNT_W'(3) * CNT_W'($past(half_cyc)) - CNT_W'(1);
  endproperty
  a_stop_1p5: assert property (p_stop_1p5) else $error("stop length wrong");
  property p_one_stop;
    @(posedge sys_clk) disable iff (rst)
    rx_done |=> rx_state_reg == SER_IDLE;
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("receiver kept stop");
  property p_stick;
    @(posedge sys_clk) disable iff (rst)
    tx_state_reg == SER_PARITY && lcr_reg[LCR_STICK] |-> tx_line == !lcr_reg[LCR_EPS];
  endproperty
  a_stick: assert property (p_stick) else $error("stick parity level wrong");
  property p_break;
    @(posedge sys_clk) disable iff (rst)
    lcr_reg[LCR_BREAK] && !mcr_reg[MCR_LOOP] |=> !serial_out;
  endproperty
  a_break: assert property (p_break) else $error("break not low");
  property p_iir_fifo;
    @(posedge sys_clk) disable iff (rst)
    rd_iir && fifo_en_reg |=> bus_rdata[7:6] == IIR_FIFO_ON;
  endproperty
  a_iir_fifo: assert property (p_iir_fifo) else $error("INTERRUPT_IDENTIFICATION FIFO bits low");
endmodule // uflfc_top

// File: test/uflfc_term_model.sv
// Remote terminal model that drives the receive line
module uflfc_term_model (
  input wire logic sys_clk,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle marking level until a frame starts
  initial line_out = 1'b1;
  // Start, data LSB first, one stop; two clocks a bit at divisor 1
  task automatic send(input logic [7:0] d, input int n);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < n + 2; i++)
    begin
      // Stop bit follows the last used data bit
      line_out = (i == n + 1) ? 1'b1 : f[i];
      repeat (2) @(negedge sys_clk);
    end
  endtask
endmodule // uflfc_term_model

// File: test/tb_top.sv
// Self-checking bench for the serial port block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import uflfc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] v;
  logic sin;
  logic sout;
  logic dtr_n;
  logic rts_n;
  // Expected read values and the bits that matter in each
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  int err_total = 0;
  int n_compared = 0;
  always #10 sys_clk = ~sys_clk;
  // Modem inputs idle; their logic is outside this block's rules
  uflfc_top u_uflfc_top (.sys_clk(sys_clk), .rst(rst), .serial_port_select_n(sel_n), .bus_addr(addr),
    .bus_rd(rd), .bus_wr(wr), .bus_wdata(wdata), .bus_rdata(rdata), .serial_in(sin), .serial_out(sout),
    .cts_n(1'b1), .dsr_n(1'b1), .ri_n(1'b1), .dcd_n(1'b1), .dtr_n(dtr_n), .rts_n(rts_n));
  uflfc_term_model u_uflfc_term_model (.sys_clk(sys_clk), .line_out(sin));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, expv, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One strobe cycle from falling edge to falling edge; s is the select level
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic s);
    sel_n = s;
    addr = a;
    wdata = d;
    wr = w;
    rd = ~w;
    @(negedge sys_clk);
    wr = 1'b0;
    rd = 1'b0;
    sel_n = 1'b1;
  endtask
  // Read with the expectation noted first
  task automatic rdx(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    acc(1'b0, a, 8'h00, 1'b0);
  endtask
  // Monitor: a taken read answers after its edge
  always @(posedge sys_clk)
    if (!rst && !sel_n && rd)
    begin
      @(negedge sys_clk);
      chk("bus_rdata", rdata & msk_q[0], exp_q.pop_front() & msk_q[0]);
      void'(msk_q.pop_front());
    end
  // Hang guard
  initial
  begin
    #1000000;
    err_total++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'hb32b));
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    rdx(3'h3, 8'h00, 8'hff);
    rdx(3'h2, 8'h00, 8'hc0);
    v = 8'($urandom());
    acc(1'b1, 3'h7, v, 1'b0);
    acc(1'b1, 3'h7, ~v, 1'b1);
    rdx(3'h7, v, 8'hff);
    acc(1'b1, 3'h3, v | 8'h80, 1'b0);
    rdx(3'h3, v | 8'h80, 8'hff);
    acc(1'b1, 3'h0, ~v, 1'b0);
    acc(1'b1, 3'h1, v, 1'b0);
    rdx(3'h0, ~v, 8'hff);
    rdx(3'h1, v, 8'hff);
    // Divisor 1 keeps bit times short
    acc(1'b1, 3'h0, 8'h01, 1'b0);
    acc(1'b1, 3'h1, 8'h00, 1'b0);
    acc(1'b1, 3'h3, 8'h03, 1'b0);
    acc(1'b1, 3'h1, v, 1'b0);
    rdx(3'h1, v & 8'h0f, 8'hff);
    acc(1'b1, 3'h2, 8'h01, 1'b0);
    rdx(3'h2, 8'hc0, 8'hc0);
    // Every word length, unused high bits read as zero
    for (int n = 0; n < 4; n++)
    begin
      acc(1'b1, 3'h3, 8'(n), 1'b0);
      v = 8'($urandom());
      u_uflfc_term_model.send(v, n + 5);
      repeat (4) @(negedge sys_clk);
      rdx(3'h0, v & (8'hff >> (3 - n)), 8'hff);
    end
    u_uflfc_term_model.send(8'ha5, 8);
    repeat (4) @(negedge sys_clk);
    rdx(3'h5, 8'h01, 8'h01);
    acc(1'b1, 3'h2, 8'h03, 1'b0);
    rdx(3'h5, 8'h00, 8'h01);
    // Trigger of four: no data interrupt until the fourth byte
    acc(1'b1, 3'h1, 8'h01, 1'b0);
    acc(1'b1, 3'h2, 8'h47, 1'b0);
    for (int i = 1; i <= 4; i++)
    begin
      u_uflfc_term_model.send(8'(i), 8);
      repeat (4) @(negedge sys_clk);
      rdx(3'h2, (i == 4) ? 8'hc4 : 8'hc1, 8'hcf);
    end
    acc(1'b1, 3'h2, 8'h00, 1'b0);
    rdx(3'h5, 8'h00, 8'h01);
    rdx(3'h2, 8'h00, 8'hc0);
    // Break holds the line low, release restores idle
    acc(1'b1, 3'h0, 8'h00, 1'b0);
    acc(1'b1, 3'h3, 8'h43, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("serial_out", {7'h0, sout}, 8'h00);
    // Host waits for the pad to drain before release
    repeat (30) @(negedge sys_clk);
    rdx(3'h5, 8'h40, 8'h40);
    acc(1'b1, 3'h3, 8'h03, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("serial_out", {7'h0, sout}, 8'h01);
    // Start bit then data bit 0 on the pin
    acc(1'b1, 3'h0, 8'h01, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("tx_start", {7'h0, sout}, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("tx_bit0", {7'h0, sout}, 8'h01);
    repeat (30) @(negedge sys_clk);
    // Modem outputs follow the control register
    acc(1'b1, 3'h4, 8'h03, 1'b0);
    @(negedge sys_clk);
    chk("modem_out", {6'h0, dtr_n, rts_n}, 8'h00);
    // Loopback: stick parity with two stops, then odd parity with 1.5 stops
    acc(1'b1, 3'h4, 8'h13, 1'b0);
    @(negedge sys_clk);
    chk("modem_out", {6'h0, dtr_n, rts_n}, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b1, 3'h3, (k == 1) ? 8'h0c : 8'h3f, 1'b0);
      v = 8'($urandom());
      acc(1'b1, 3'h0, v, 1'b0);
      repeat (40) @(negedge sys_clk);
      rdx(3'h5, 8'h61, 8'h7f);
      rdx(3'h0, v & ((k == 1) ? 8'h1f : 8'hff), 8'hff);
    end
    close_out();
  end
endmodule // tb_top
